// ==== hw/sar_proc_end.sv ====
// Processor end: successive approximation sequencer over the memory bus.
// Assumes the converter end answers reads with ready on the same clock.
`timescale 1ns/100ps
module sar_proc_end #(
  parameter int CODE_W = sar_pkg::CODE_BITS
)(
  input wire logic clk,
  input wire logic nrst,
  sar_bus_if.proc bus,
  input wire logic start,
  output logic done,
  output logic [CODE_W-1:0] result
);
  // Conversion steps: a trial read, its answer, and a merge step for a kept bit.
  typedef enum {idle, trial, wait_ans, merge} state_e;
  state_e state;
  state_e next_state;
  // Next values are formed combinationally; the registers below only load them.
  logic [CODE_W-1:0] code;
  logic [CODE_W-1:0] next_code;
  logic [CODE_W-1:0] test_bit;
  logic [CODE_W-1:0] next_test_bit;
  logic [CODE_W-1:0] cleared_code;
  logic [CODE_W-1:0] lower_bit;
  logic [sar_pkg::ADDR_BITS-1:0] trial_addr;
  logic kept;
  logic last_bit;
  logic finish;

  // Per bit: the tested bit is dropped when the converter was above the input,
  // and each bit hands its trial mark down to the next lower bit.
  generate
    for (genvar i = 0; i < CODE_W; i = i + 1)
    begin : g_bit
      assign cleared_code[i] = code[i] & ~(test_bit[i] & bus.data_bit);
      if (i == CODE_W - 1)
      begin : g_top
        // The top bit has nothing above it to hand down.
        assign lower_bit[i] = 1'b0;
      end
      else
      begin : g_low
        assign lower_bit[i] = test_bit[i + 1];
      end
    end
  endgenerate

  // A low decision bit means the converter stayed below the input, so the bit is kept.
  // The lowest bit under test marks the final trial of a conversion.
  assign kept = !bus.data_bit;
  assign last_bit = test_bit[0];
  assign finish = (state == wait_ans && bus.ready && !kept && last_bit) ||
    (state == merge && last_bit);

  // Next state, trial code and bit under test.
  // A kept bit costs an extra merge step, so the conversion time depends on the input.
  // Every output of this process gets a default first, so no path leaves a latch.
  always_comb
  begin
    next_state = state;
    next_code = code;
    next_test_bit = test_bit;
    case (state)
      idle:
        if (start)
        begin
          next_state = trial;
          next_code = {1'b1, {(CODE_W - 1){1'b0}}};
          next_test_bit = {1'b1, {(CODE_W - 1){1'b0}}};
        end
      trial:
        next_state = wait_ans;
      // Only a ready pulse carries a valid decision.
      wait_ans:
        if (bus.ready)
        begin
          if (kept)
            next_state = merge;
          else if (last_bit)
          begin
            next_state = idle;
            next_code = cleared_code;
          end
          else
          begin
            next_state = trial;
            next_code = cleared_code | lower_bit;
            next_test_bit = lower_bit;
          end
        end
      // The kept bit is already set; this step moves on to the next bit, or ends the conversion after the last bit.
      merge:
        if (last_bit)
          next_state = idle;
        else
        begin
          next_state = trial;
          next_code = code | lower_bit;
          next_test_bit = lower_bit;
        end
      default:
        next_state = idle;
    endcase
  end

  // State register; reset parks the sequencer idle with no read in progress.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state <= idle;
    else
      state <= next_state;
  end

  // Trial code; cleared in reset so no stale trial is left on the bus.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      code <= '0;
    else
      code <= next_code;
  end

  // Bit under test, one-hot, walking from the top bit down.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      test_bit <= '0;
    else
      test_bit <= next_test_bit;
  end

  // Trial address: select line high, trial code on the low lines.
  // The lines in between stay low, which keeps reads inside the 256-address converter region.
  always_comb
  begin
    trial_addr = '0;
    trial_addr[CODE_W-1:0] = code;
    trial_addr[sar_pkg::IO_SEL_BIT] = 1'b1;
  end

  // Address register; it follows the trial code one cycle later.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bus.addr <= '0;
    else
      bus.addr <= trial_addr;
  end

  // Read strobe rises on a trial and stays up until the converter answers,
  // so the address never moves under a read that is still settling.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bus.mem_read_strobe <= 1'b0;
    else
      bus.mem_read_strobe <= (state == trial) || (state == wait_ans && !bus.ready);
  end

  // The converter is only ever read, so the write strobe stays low.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bus.mem_write_strobe <= 1'b0;
    else
      bus.mem_write_strobe <= 1'b0;
  end

  // Done drops on a new start and rises with the last decision, or one cycle later after the merge step when the last bit is kept.
  // A start during a conversion is ignored; done only clears when it can be taken.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      done <= 1'b0;
    else if (start && state == idle)
      done <= 1'b0;
    else if (finish)
      done <= 1'b1;
  end

  // Result register holds the final code until the next conversion ends.
  // Loading from the next code keeps result and done in step on the same edge.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      result <= '0;
    else if (finish)
      result <= next_code;
  end
endmodule : sar_proc_end

// ==== hw/sar_pkg.sv ====
// Shared constants for the memory-mapped successive approximation converter.
// Assumes both ends run from one clock and meet through sar_bus_if.
package sar_pkg;
  localparam int CODE_BITS = 8;
  localparam int ADDR_BITS = 16;
  localparam int IO_SEL_BIT = 15;
  localparam int SETTLE_NS = 0;
  localparam int CLK_NS = 10;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;
  localparam int REGION_8 = 256;
  localparam int REGION_10 = 1024;
  localparam int REGION_12 = 4096;
endpackage : sar_pkg

// ==== hw/sar_bus_if.sv ====
// Memory bus between the sequencing processor end and the converter end.
// Assumes a single clock shared by both ends.
`timescale 1ns/100ps
interface sar_bus_if;
  logic [sar_pkg::ADDR_BITS-1:0] addr;
  logic mem_read_strobe;
  logic mem_write_strobe;
  logic data_bit;
  logic ready;

  modport proc
  (
    output addr,
    output mem_read_strobe,
    output mem_write_strobe,
    input data_bit,
    input ready
  );

  modport conv
  (
    input addr,
    input mem_read_strobe,
    input mem_write_strobe,
    output data_bit,
    output ready
  );
endinterface : sar_bus_if

// ==== hw/sar_conv_end.sv ====
// Converter end: trial code latch from address, comparator decision readback.
// Assumes the comparator level comes from outside the clock domain.
`timescale 1ns/100ps
module sar_conv_end #(
  parameter int CODE_W = sar_pkg::CODE_BITS,
  parameter int SETTLE = sar_pkg::SETTLE_CYCLES
)(
  input wire logic clk,
  input wire logic nrst,
  sar_bus_if.conv bus,
  input wire logic comp_above,
  output logic [CODE_W-1:0] dac_code
);
  logic cmp_s1;
  logic cmp_s2;
  logic sel;
  logic [15:0] settle_cnt;

  // Read strobe gated with the I/O select line.
  assign sel = bus.addr[sar_pkg::IO_SEL_BIT] & bus.mem_read_strobe;

  // Two-stage synchroniser for the comparator output.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end
    else
    begin
      cmp_s1 <= comp_above;
      cmp_s2 <= cmp_s1;
    end
  end

  // Low address lines drive the converter code directly.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      dac_code <= '0;
    else if (sel)
      dac_code <= bus.addr[CODE_W-1:0];
  end

  // Settling counter holds ready low while the new code settles.
  // The reload also spans the comparator synchroniser, so that the decision read back
  // belongs to the new code and not to the one before it.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      settle_cnt <= '0;
    else if (sel && bus.addr[CODE_W-1:0] != dac_code)
      settle_cnt <= 16'(SETTLE + sar_pkg::SYNC_STAGES);
    else if (settle_cnt != 16'h0000)
      settle_cnt <= settle_cnt - 16'h0001;
  end

  // Read answers with the decision; ready marks it valid for one cycle only.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus.data_bit <= 1'b0;
      bus.ready <= 1'b0;
    end
    else
    begin
      bus.data_bit <= cmp_s2;
      bus.ready <= sel && bus.addr[CODE_W-1:0] == dac_code && settle_cnt == 16'h0000 &&
        !bus.ready;
    end
  end
endmodule : sar_conv_end

// ==== verif/sar_bus_asserts.sv ====
// Checker for the converter memory bus, fed with the interface signals.
// Assumes one clock and a processor end that holds each read until ready.
`timescale 1ns/100ps
module sar_bus_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [sar_pkg::ADDR_BITS-1:0] addr,
  input wire logic mem_read_strobe,
  input wire logic mem_write_strobe,
  input wire logic data_bit,
  input wire logic ready
);
  // Cycles from a rising read strobe to ready: latch, synchroniser, settling, answer.
  localparam int READY_MAX = 2 + sar_pkg::SYNC_STAGES + sar_pkg::SETTLE_CYCLES;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Answers come only to selected reads and leave the bus timing alone.
  a_ready_select: assert property (ready |-> addr[15] && mem_read_strobe)
    else $error("ready without a selected read");
  a_ready_pulse: assert property (ready |=> !ready)
    else $error("ready held past one cycle");
  a_write_idle: assert property (!mem_write_strobe)
    else $error("write strobe raised");
  a_ready_bound: assert property ($rose(mem_read_strobe) && addr[15] |-> ##[1:READY_MAX] ready)
    else $error("read not answered in time");
  a_addr_steady: assert property (mem_read_strobe && !ready |=> $stable(addr))
    else $error("trial code moved during a read");
  a_region_map: assert property (mem_read_strobe |-> addr[14:8] == 7'h00)
    else $error("read outside the converter region");
  a_quiet_idle: assert property (!mem_read_strobe [*2] |=> !ready)
    else $error("ready with no read");
  a_settle_gap: assert property (ready |-> $past(mem_read_strobe, READY_MAX))
    else $error("ready before the code settled");
  // Both comparator answers and a read start are seen.
  c_above: cover property (ready && data_bit);
  c_below: cover property (ready && !data_bit);
  c_read: cover property ($rose(mem_read_strobe));
endmodule : sar_bus_asserts

// ==== verif/memory_mapped_sar_adc_control_tb_top.sv ====
// Testbench joining the processor end and the converter end.
// Assumes an ideal comparator that tracks the trial code at once.
`timescale 1ns/100ps
module memory_mapped_sar_adc_control_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic done;
  logic comp_above;
  logic [7:0] result;
  logic [7:0] dac_code;
  logic [7:0] vin = 8'h00;
  int dur_low = 0;
  int dur_high = 0;
  int mismatches = 0;
  int cmp_count = 0;
  sar_bus_if bus ();
  sar_proc_end u_sar_proc_end (.clk(clk), .nrst(nrst), .bus(bus), .start(start),
    .done(done), .result(result));
  sar_conv_end u_sar_conv_end (.clk(clk), .nrst(nrst), .bus(bus), .comp_above(comp_above),
    .dac_code(dac_code));
  sar_bus_asserts u_sar_bus_asserts (.clk(clk), .nrst(nrst), .addr(bus.addr),
    .mem_read_strobe(bus.mem_read_strobe), .mem_write_strobe(bus.mem_write_strobe),
    .data_bit(bus.data_bit), .ready(bus.ready));
  // Clock and the comparator, high while the trial code is above the input.
  always #5 clk = ~clk;
  assign comp_above = dac_code > vin;
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Runs one conversion, judges the first trial and the result, returns its length.
  task automatic conv(input logic [7:0] v, output int dur);
    int n;
    @(posedge clk);
    vin <= v;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (bus.ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    chk("first trial", 8'h80, dac_code);
    chk("trial address", 8'h80, bus.addr[7:0]);
    chk("select line", 8'h01, {7'h00, bus.addr[15]});
    chk("done low", 8'h00, {7'h00, done});
    while (done !== 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    chk("done high", 8'h01, {7'h00, done});
    chk("result", v, result);
    dur = n;
  endtask : conv
  // Every bit kept, then every bit cleared; each kept bit costs one merge step.
  task automatic t_extremes;
    conv(8'hFF, dur_high);
    conv(8'h00, dur_low);
    chk("kept bit cost", 8'(sar_pkg::CODE_BITS), 8'(dur_high - dur_low));
    $display("test extremes done");
  endtask : t_extremes
  // Back to back conversions; the result holds while idle.
  task automatic t_hold;
    int dur;
    conv(8'h80, dur);
    conv(8'h5A, dur);
    chk("length in range", 8'h01, {7'h00, dur >= dur_low && dur <= dur_high});
    repeat (20) @(negedge clk);
    chk("held result", 8'h5A, result);
    chk("held done", 8'h01, {7'h00, done});
    $display("test hold done");
  endtask : t_hold
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  // Reset for four cycles, then the scenarios.
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_extremes();
    t_hold();
    close_out();
  end
  // Watchdog well beyond the expected run.
  initial
  begin
    #100000;
    mismatches++;
    close_out();
  end
endmodule : memory_mapped_sar_adc_control_tb_top
